// File: pwm_timer_unit.sv
// Four PWM base timers with channels, dead-time generators and a quadrature decoder.
// Operation
// - Four independent timers, each with a 16-bit counter for PWM and capture.
// - Counter counts up only, symmetric up/down, or asymmetric up/down.
// - Count clock is the peripheral clock or the auxiliary clock.
// - Selected clock passes a prescaler set by a 3-bit field.
// - Buffered values move into use at zero, period, on write, or together.
// - Single-shot or auto-reload operation; timer raises its own interrupts.
// - Eight channels per timer, each a PWM comparator or capture input.
// - New compare value applies at zero, at period, or immediately.
// - Capture records the counter on rising, falling or both input edges.
// - Channel interrupt enable, skip count, edge type and software force.
// - PWM waveform takes a programmable phase delay.
// - Each channel output may be inverted.
// - Selected rising or falling output edge starts the ADC conversion sequencer.
// - Dead-time generator delays the rising edge by a 12-bit count.
// - Dead-time generator delays the falling edge by a separate 12-bit count.
// - Quadrature decoder: four modes, direction, four enableable interrupts.
`timescale 1ns/1ps
`include "pwm_timer_consts.svh"
module pwm_timer_unit import pwm_timer_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Register port.
  input wire logic [10:0] addr,
  input wire logic [15:0] wdata,
  input wire logic we,
  input wire logic re,
  output logic [15:0] rdata,
  // Clock and capture pins.
  input wire logic aux_clk,
  input wire logic [31:0] cap_in,
  // PWM and gate-driver outputs.
  output logic [31:0] pwm_out,
  output logic [3:0] dt_hi,
  output logic [3:0] dt_lo,
  // Sequencer triggers and interrupts.
  output logic [3:0] adc_conversion_sequencer_start,
  output logic [3:0] timer_irq,
  // Quadrature decoder pins and outputs.
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_idx,
  output logic quadrature_decoder_irq,
  output logic quadrature_decoder_dir
);
  // Prescaler terminal count: 2^div source ticks per counter tick.
  function automatic logic [7:0] div_limit(input logic [2:0] d);
    div_limit = ~(8'hff << d);
  endfunction

  // Reset release through two flip-flops.
  logic [1:0] rst_ff;
  wire rst_n = rst_ff[1];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rst_ff <= 2'b00;
    else rst_ff <= {rst_ff[0], 1'b1};
  end

  // Pin synchronisers: three stages, a change counts once stages two and three agree.
  logic [35:0] s1, s2, s3, filt, filt_q;
  wire [35:0] pin_raw = {enc_idx, enc_b, enc_a, aux_clk, cap_in};
  wire [35:0] agree = ~(s2 ^ s3);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 36'h0;
      s2 <= 36'h0;
      s3 <= 36'h0;
      filt <= 36'h0;
      filt_q <= 36'h0;
    end else begin
      s1 <= pin_raw;
      s2 <= s1;
      s3 <= s2;
      filt <= (s3 & agree) | (filt & ~agree);
      filt_q <= filt;
    end
  end
  // The auxiliary clock is sampled and filtered, so it must stay at or below a quarter of the system clock.
  wire aux_rise = filt[32] & ~filt_q[32];

  // Address decode shared by all register groups.
  wire qsel = addr[`ENC_SPACE];
  wire [1:0] tsel = addr[9:8];
  wire [7:0] roff = addr[7:0];
  wire [4:0] ci = {tsel, roff[2:0]};

  chan_if cif[32] ();
  logic [15:0] ch_ctrl [32];
  logic [15:0] ch_val [32];
  logic [15:0] ch_dly [32];
  logic [31:0] ch_pwm, ch_flag, ch_adc;
  logic [15:0] tctrl [4];
  logic [15:0] period [4];
  logic [15:0] count [4];
  logic [15:0] status [4];
  logic [3:0] dtc [4];
  logic [11:0] dtr [4];
  logic [11:0] dtf [4];

  genvar t, c;
  generate
    for (t = 0; t < `NUM_TIMERS; t++) begin : g_tm
      logic [15:0] pshadow;
      logic [7:0] presc;
      logic down;
      logic [11:0] dcnt;
      logic dsrc;
      dt_state_e dst;
      wire wr_t = we && !qsel && tsel == 2'(t);
      wire wr_ctrl = wr_t && roff == `TM_CTRL;
      wire wr_per = wr_t && roff == `TM_PERIOD;
      wire latch_all = wr_ctrl && wdata[`TC_LATCH_ALL];
      wire [1:0] mode = tctrl[t][`TC_MODE];
      wire [1:0] lmode = tctrl[t][`TC_LATCH];
      wire src_tick = tctrl[t][`TC_SRC] ? aux_rise : 1'b1;
      wire presc_hit = src_tick && presc >= div_limit(tctrl[t][`TC_DIV]);
      wire tick = tctrl[t][`TC_EN] && presc_hit;
      wire at_zero = count[t] == 16'h0000;
      wire at_per = count[t] == period[t];
      wire zero_evt = tick && at_zero;
      wire period_evt = tick && at_per;
      wire updn = mode != cnt_up;
      wire stop = tctrl[t][`TC_ONESHOT] && (updn ? (down && zero_evt) : period_evt);
      wire per_load = (lmode == latch_zero && zero_evt) || (lmode == latch_period && period_evt)
        || (lmode == latch_sync && latch_all);
      wire [15:0] st_set = {6'h00, period_evt, zero_evt, ch_flag[t*8 +: 8]};
      wire [15:0] st_clr = (wr_t && roff == `TM_STATUS) ? wdata : 16'h0000;
      wire [15:0] st_mask = {6'h00, tctrl[t][`TC_IE_PER], tctrl[t][`TC_IE_ZERO],
        ch_ctrl[t*8+7][6], ch_ctrl[t*8+6][6], ch_ctrl[t*8+5][6], ch_ctrl[t*8+4][6],
        ch_ctrl[t*8+3][6], ch_ctrl[t*8+2][6], ch_ctrl[t*8+1][6], ch_ctrl[t*8][6]};

      // Channels of this timer.
      for (c = 0; c < `NUM_CH; c++) begin : g_ch
        localparam int I = t * 8 + c;
        wire ch_hit = wr_t && roff[2:0] == 3'(c);
        assign cif[I].tick = tick;
        assign cif[I].zero_evt = zero_evt;
        assign cif[I].period_evt = period_evt;
        assign cif[I].latch_all = latch_all;
        assign cif[I].all_mode = lmode == latch_sync;
        assign cif[I].asym = mode == cnt_asym;
        assign cif[I].count = count[t];
        assign cif[I].wr = ch_hit && (roff[7:3] == `PG_CH_CTRL || roff[7:3] == `PG_CH_VALUE
          || roff[7:3] == `PG_CH_DELAY);
        assign cif[I].sel = (roff[7:3] == `PG_CH_CTRL) ? 2'h0
          : (roff[7:3] == `PG_CH_VALUE) ? 2'h1 : 2'h2;
        assign cif[I].wdata = wdata;
        assign cif[I].cap_level = filt[I];
        assign ch_ctrl[I] = cif[I].ctrl;
        assign ch_val[I] = cif[I].value;
        assign ch_dly[I] = cif[I].delay;
        assign ch_pwm[I] = cif[I].pwm;
        assign ch_flag[I] = cif[I].flag_evt;
        assign ch_adc[I] = cif[I].adc_evt;
        pwm_channel u_ch (.clk(clk), .rst_n(rst_n), .cif(cif[I]));
      end

      // Base timer control, period buffer and counter.
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          tctrl[t] <= `CTRL_RST;
          period[t] <= `PERIOD_RST;
          pshadow <= `PERIOD_RST;
          count[t] <= 16'h0000;
          down <= 1'b0;
          presc <= 8'h00;
        end else begin
          if (wr_ctrl) tctrl[t] <= wdata & ~(16'h1 << `TC_LATCH_ALL);
          else if (stop) tctrl[t][`TC_EN] <= 1'b0;
          if (wr_per) pshadow <= wdata;
          if (wr_per && lmode == latch_write) period[t] <= wdata;
          else if (per_load) period[t] <= pshadow;
          if (!tctrl[t][`TC_EN]) presc <= 8'h00;
          else if (src_tick) presc <= presc_hit ? 8'h00 : presc + 8'h01;
          if (tick) begin
            if (!updn) count[t] <= at_per ? 16'h0000 : count[t] + 16'h0001;
            else if (!down) begin
              down <= at_per;
              count[t] <= at_per ? count[t] - 16'h0001 : count[t] + 16'h0001;
            end else begin
              down <= !at_zero;
              count[t] <= at_zero ? count[t] + 16'h0001 : count[t] - 16'h0001;
            end
          end
        end
      end

      // Sticky timer status: a set in the same cycle as a clear wins.
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          status[t] <= 16'h0000;
          timer_irq[t] <= 1'b0;
          adc_conversion_sequencer_start[t] <= 1'b0;
        end else begin
          status[t] <= (status[t] & ~st_clr) | st_set;
          timer_irq[t] <= |(status[t] & st_mask);
          adc_conversion_sequencer_start[t] <= |ch_adc[t*8 +: 8];
        end
      end

      // Dead-time generator: whichever output is on drops at once, the other rises after its delay.
      wire dsel = ch_pwm[t*8 + 32'(dtc[t][`DC_SRC])];
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          dtc[t] <= 4'h0;
          dtr[t] <= `DT_DELAY_RST;
          dtf[t] <= `DT_DELAY_RST;
          dst <= dt_low;
          dcnt <= 12'h000;
          dsrc <= 1'b0;
          dt_hi[t] <= 1'b0;
          dt_lo[t] <= 1'b0;
        end else begin
          if (wr_t && roff == `TM_DT_CTRL) dtc[t] <= wdata[3:0];
          if (wr_t && roff == `TM_DT_RISE) dtr[t] <= wdata[11:0];
          if (wr_t && roff == `TM_DT_FALL) dtf[t] <= wdata[11:0];
          if (!dtc[t][`DC_EN]) begin
            dt_hi[t] <= dsel;
            dt_lo[t] <= ~dsel;
            dst <= dsel ? dt_high : dt_low;
          end else begin
            case (dst)
              dt_high: begin
                if (!dsel) begin
                  dt_hi[t] <= 1'b0;
                  dcnt <= dtf[t];
                  dsrc <= 1'b0;
                  dst <= dt_wait;
                end
              end
              dt_low: begin
                if (dsel) begin
                  dt_lo[t] <= 1'b0;
                  dcnt <= dtr[t];
                  dsrc <= 1'b1;
                  dst <= dt_wait;
                end
              end
              dt_wait: begin
                if (dsel != dsrc) begin
                  dsrc <= dsel;
                  dcnt <= dsel ? dtr[t] : dtf[t];
                end else if (dcnt == 12'h000) begin
                  dt_hi[t] <= dsrc;
                  dt_lo[t] <= ~dsrc;
                  dst <= dsrc ? dt_high : dt_low;
                end else if (tick) dcnt <= dcnt - 12'h001;
              end
              default: dst <= dt_low;
            endcase
          end
        end
      end
    end
  endgenerate

  // PWM pins come straight from the channel output registers.
  assign pwm_out = ch_pwm;

  // Quadrature decoder edges and step direction per mode.
  logic [15:0] qctrl, qcount, qmax;
  logic [3:0] qflag;
  wire qa = filt[33];
  wire qb = filt[34];
  wire a_r = qa & ~filt_q[33];
  wire a_e = qa ^ filt_q[33];
  wire b_r = qb & ~filt_q[34];
  wire b_e = qb ^ filt_q[34];
  wire idx_r = filt[35] & ~filt_q[35];
  wire [1:0] qmode = qctrl[`QC_MODE];
  wire q_step = qctrl[`QC_EN] && ((qmode == qp_x2) ? a_e
    : (qmode == qp_x4) ? (a_e | b_e) : a_r);
  wire q_up = (qmode == qp_step) ? qb : (qmode == qp_x1) ? ~qb
    : (a_e ? (qa ^ qb) : ~(qa ^ qb));
  wire q_wrap = q_step && (q_up ? qcount == qmax : qcount == 16'h0000);
  wire q_idx = qctrl[`QC_EN] && idx_r;
  wire [3:0] q_set = {q_wrap, q_idx, qctrl[`QC_EN] & b_r, qctrl[`QC_EN] & a_r};
  wire wr_q = we && qsel;
  wire [3:0] q_clr = (wr_q && roff == `QP_STATUS) ? wdata[3:0] : 4'h0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      qctrl <= `CTRL_RST;
      qmax <= `QP_MAX_RST;
      qcount <= 16'h0000;
      qflag <= 4'h0;
      quadrature_decoder_dir <= 1'b0;
      quadrature_decoder_irq <= 1'b0;
    end else begin
      if (wr_q && roff == `QP_CTRL) qctrl <= wdata;
      if (wr_q && roff == `QP_MAX) qmax <= wdata;
      if (q_idx) qcount <= 16'h0000;
      else if (q_step) qcount <= q_wrap ? (q_up ? 16'h0000 : qmax)
        : (q_up ? qcount + 16'h0001 : qcount - 16'h0001);
      if (q_step) quadrature_decoder_dir <= q_up;
      qflag <= (qflag & ~q_clr) | q_set;
      quadrature_decoder_irq <= |(qflag & qctrl[`QC_IE]);
    end
  end

  // Read mux; unmapped offsets read as zero.
  wire [15:0] qmux = (roff == `QP_CTRL) ? qctrl : (roff == `QP_COUNT) ? qcount
    : (roff == `QP_STATUS) ? {11'h000, quadrature_decoder_dir, qflag}
    : (roff == `QP_MAX) ? qmax : 16'h0000;
  wire [15:0] tmux = (roff == `TM_CTRL) ? tctrl[tsel] : (roff == `TM_PERIOD) ? period[tsel]
    : (roff == `TM_COUNT) ? count[tsel] : (roff == `TM_STATUS) ? status[tsel]
    : (roff == `TM_DT_CTRL) ? {12'h000, dtc[tsel]}
    : (roff == `TM_DT_RISE) ? {4'h0, dtr[tsel]} : (roff == `TM_DT_FALL) ? {4'h0, dtf[tsel]}
    : (roff[7:3] == `PG_CH_CTRL) ? ch_ctrl[ci] : (roff[7:3] == `PG_CH_VALUE) ? ch_val[ci]
    : (roff[7:3] == `PG_CH_DELAY) ? ch_dly[ci] : 16'h0000;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rdata <= 16'h0000;
    else rdata <= re ? (qsel ? qmux : tmux) : 16'h0000;
  end
endmodule

// File: pwm_timer_consts.svh
// Register offsets, field positions and reset values of the PWM timer block.
`ifndef PWM_TIMER_CONSTS_SVH
`define PWM_TIMER_CONSTS_SVH
`define NUM_TIMERS 4
`define NUM_CH 8
`define ENC_SPACE 10
`define TM_CTRL 8'h00
`define TM_PERIOD 8'h01
`define TM_COUNT 8'h02
`define TM_STATUS 8'h03
`define TM_DT_CTRL 8'h04
`define TM_DT_RISE 8'h05
`define TM_DT_FALL 8'h06
`define PG_CH_CTRL 5'h02
`define PG_CH_VALUE 5'h04
`define PG_CH_DELAY 5'h06
`define QP_CTRL 8'h00
`define QP_COUNT 8'h01
`define QP_STATUS 8'h02
`define QP_MAX 8'h03
`define TC_MODE 1:0
`define TC_SRC 2
`define TC_DIV 5:3
`define TC_LATCH 7:6
`define TC_ONESHOT 8
`define TC_EN 9
`define TC_IE_ZERO 10
`define TC_IE_PER 11
`define TC_LATCH_ALL 12
`define ST_ZERO 8
`define ST_PER 9
`define CC_CAP 0
`define CC_CLATCH 2:1
`define CC_CEDGE 4:3
`define CC_INV 5
`define CC_IE 6
`define CC_ITYPE 8:7
`define CC_SKIP 11:9
`define CC_ADC_RISE 12
`define CC_ADC_FALL 13
`define CC_FORCE 14
`define DC_EN 0
`define DC_SRC 3:1
`define QC_EN 0
`define QC_MODE 2:1
`define QC_IE 6:3
`define QS_DIR 4
`define CTRL_RST 16'h0000
`define PERIOD_RST 16'hffff
`define QP_MAX_RST 16'hffff
`define DT_DELAY_RST 12'h000
`endif

// File: pwm_timer_pkg.sv
// Types shared by the PWM timer block.
package pwm_timer_pkg;
  typedef enum logic [1:0] {cnt_up = 2'h0, cnt_updown = 2'h1, cnt_asym = 2'h2} cnt_mode_e;
  typedef enum logic [1:0] {
    latch_zero = 2'h0, latch_period = 2'h1, latch_write = 2'h2, latch_sync = 2'h3
  } latch_mode_e;
  typedef enum logic [2:0] {dt_wait = 3'b001, dt_high = 3'b010, dt_low = 3'b100} dt_state_e;
  typedef enum logic [1:0] {qp_x1 = 2'h0, qp_x2 = 2'h1, qp_x4 = 2'h2, qp_step = 2'h3} qp_mode_e;
endpackage

// File: chan_if.sv
// Signals between a base timer and one of its compare/capture channels.
`timescale 1ns/1ps
interface chan_if;
  logic tick;
  logic zero_evt;
  logic period_evt;
  logic latch_all;
  logic all_mode;
  logic asym;
  logic [15:0] count;
  logic wr;
  logic [1:0] sel;
  logic [15:0] wdata;
  logic cap_level;
  logic [15:0] ctrl;
  logic [15:0] value;
  logic [15:0] delay;
  logic pwm;
  logic flag_evt;
  logic adc_evt;
  modport timer (output tick, zero_evt, period_evt, latch_all, all_mode, asym, count, wr, sel,
    wdata, cap_level, input ctrl, value, delay, pwm, flag_evt, adc_evt);
  modport chan (input tick, zero_evt, period_evt, latch_all, all_mode, asym, count, wr, sel,
    wdata, cap_level, output ctrl, value, delay, pwm, flag_evt, adc_evt);
endinterface

// File: pwm_channel.sv
// One compare/capture channel: PWM window, phase delay, capture, interrupt and ADC events.
`timescale 1ns/1ps
`include "pwm_timer_consts.svh"
module pwm_channel import pwm_timer_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Link to the owning base timer.
  chan_if.chan cif
);
  logic [15:0] ctrl;
  logic [15:0] shadow;
  logic [15:0] active;
  logic [15:0] delay;
  logic [15:0] capture;
  logic pwm;
  logic cap_prev;
  logic [2:0] skip_cnt;
  logic flag_evt;
  logic adc_evt;

  // Output window and edge detection; the window starts at the phase delay.
  wire cap_mode = ctrl[`CC_CAP];
  wire [16:0] win_lo = {1'b0, delay};
  wire [16:0] win_hi = win_lo + {1'b0, active};
  wire [16:0] cnt_w = {1'b0, cif.count};
  wire in_win = (cnt_w >= win_lo) && (cnt_w < win_hi);
  wire next_pwm = cap_mode ? 1'b0 : (in_win ^ ctrl[`CC_INV]);
  wire rise_o = next_pwm & ~pwm;
  wire fall_o = ~next_pwm & pwm;
  wire cap_rise = cif.cap_level & ~cap_prev;
  wire cap_fall = ~cif.cap_level & cap_prev;
  wire cap_hit = cap_mode & ((ctrl[3] & cap_rise) | (ctrl[4] & cap_fall));
  wire type_hit = (ctrl[7] & rise_o) | (ctrl[8] & fall_o);
  wire int_evt = cap_mode ? cap_hit : type_hit;
  wire skip_hit = skip_cnt == ctrl[`CC_SKIP];
  wire wr_ctrl = cif.wr && cif.sel == 2'h0;
  wire wr_val = cif.wr && cif.sel == 2'h1;
  wire force_int = wr_ctrl && cif.wdata[`CC_FORCE];
  wire [1:0] clatch = ctrl[`CC_CLATCH];
  wire pol_load = (clatch == 2'h0) ? cif.zero_evt : (clatch == 2'h1) ? cif.period_evt : 1'b0;
  // A global sync latch overrides the channel policy; asym reloads at both turning points.
  wire load = cif.all_mode ? cif.latch_all : cif.asym ? (cif.zero_evt | cif.period_evt) : pol_load;
  wire load_now = wr_val && !cif.all_mode && clatch == 2'h2;

  // Configuration, buffered compare value and its transfer into use.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `CTRL_RST;
      shadow <= 16'h0000;
      active <= 16'h0000;
      delay <= 16'h0000;
    end else begin
      if (wr_ctrl) ctrl <= cif.wdata & ~(16'h1 << `CC_FORCE);
      if (wr_val) shadow <= cif.wdata;
      if (cif.wr && cif.sel == 2'h2) delay <= cif.wdata;
      if (load_now) active <= cif.wdata;
      else if (load) active <= shadow;
    end
  end

  // Capture, output register and event pulses.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture <= 16'h0000;
      pwm <= 1'b0;
      cap_prev <= 1'b0;
      skip_cnt <= 3'h0;
      flag_evt <= 1'b0;
      adc_evt <= 1'b0;
    end else begin
      cap_prev <= cif.cap_level;
      pwm <= next_pwm;
      if (cap_hit) capture <= cif.count;
      if (int_evt) skip_cnt <= skip_hit ? 3'h0 : skip_cnt + 3'h1;
      flag_evt <= (int_evt & skip_hit) | force_int;
      adc_evt <= ~cap_mode & ((ctrl[`CC_ADC_RISE] & rise_o)
        | (ctrl[`CC_ADC_FALL] & fall_o));
    end
  end

  assign cif.ctrl = ctrl;
  assign cif.value = cap_mode ? capture : shadow;
  assign cif.delay = delay;
  assign cif.pwm = pwm;
  assign cif.flag_evt = flag_evt;
  assign cif.adc_evt = adc_evt;
endmodule

// File: pwm_timer_unit_assertions.sv
// Pin-level checks of the PWM timer block, bound to its top module.
`timescale 1ns/1ps
module timer_unit_checker (
  // Clock, reset and register port.
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [10:0] addr,
  input wire logic [15:0] wdata,
  input wire logic we,
  input wire logic re,
  input wire logic [15:0] rdata,
  // Drive outputs and quadrature pins.
  input wire logic [31:0] pwm_out,
  input wire logic [3:0] dt_hi,
  input wire logic [3:0] dt_lo,
  input wire logic [3:0] adc_start,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic quadrature_decoder_dir
);
  logic dt_en, cap0;
  logic [11:0] rise_n, fall_n;
  logic [3:0] age;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Mirror the timer 0 settings, since the pins alone cannot say what is legal.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dt_en <= 1'b0;
      cap0 <= 1'b0;
      rise_n <= 12'h000;
      fall_n <= 12'h000;
      age <= 4'h0;
    end else begin
      if (we && addr == 11'h004) dt_en <= wdata[0];
      if (we && addr == 11'h005) rise_n <= wdata[11:0];
      if (we && addr == 11'h006) fall_n <= wdata[11:0];
      if (we && addr == 11'h010) cap0 <= wdata[0];
      age <= (we && addr == 11'h004) ? 4'h0 : age + {3'h0, age != 4'hf};
    end
  end
  sequence pins_still;
    ($stable(enc_a) && $stable(enc_b)) [*8];
  endsequence
  sequence hi_held;
    !dt_hi[0] [*6];
  endsequence
  rdata_idle_a: assert property (!$past(re) |-> rdata == 16'h0000)
    else $error("read data present without a read");
  dead_excl_a: assert property ((dt_hi & dt_lo) == 4'h0)
    else $error("both outputs of a dead-time pair high");
  dt_comp_a: assert property (!dt_en && age == 4'hf |-> dt_lo[0] == !dt_hi[0])
    else $error("disabled dead-time pair not complementary");
  dt_rise_gap_a: assert property (dt_en && rise_n == 12'h006 && $fell(dt_lo[0])
    |-> hi_held)
    else $error("high output rose before its delay");
  dt_fall_gap_a: assert property (dt_en && fall_n == 12'h005 && $fell(dt_hi[0])
    |-> !dt_lo[0] [*5])
    else $error("low output rose before its delay");
  cap_quiet_a: assert property (cap0 && $past(cap0, 3) |-> !pwm_out[0])
    else $error("capture channel drives its output");
  adc_pulse_a: assert property (adc_start[0] |=> !adc_start[0])
    else $error("sequencer start longer than one cycle");
  adc_cause_a: assert property ($rose(adc_start[0]) |->
    pwm_out[7:0] != $past(pwm_out[7:0], 3))
    else $error("sequencer start without an output edge");
  dir_hold_a: assert property (pins_still |=> $stable(quadrature_decoder_dir))
    else $error("direction moved without encoder edges");
endmodule
bind pwm_timer_unit timer_unit_checker chk (.clk(clk), .arst_n(arst_n), .addr(addr),
  .wdata(wdata), .we(we), .re(re), .rdata(rdata), .pwm_out(pwm_out), .dt_hi(dt_hi),
  .dt_lo(dt_lo), .adc_start(adc_conversion_sequencer_start),
  .enc_a(enc_a), .enc_b(enc_b), .quadrature_decoder_dir(quadrature_decoder_dir));

// File: gate_drive_model.sv
// Stand-in for the gate driver and conversion sequencer fed by timer 0.
`timescale 1ns/1ps
module gate_drive_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Drive pair and sequencer trigger.
  input wire logic hi_gate,
  input wire logic lo_gate,
  input wire logic seq_start,
  // What the bench inspects.
  output logic [15:0] starts,
  output logic shoot
);
  // Each trigger pulse starts one sequence; both switches on would short the leg.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      starts <= 16'h0000;
      shoot <= 1'b0;
    end else begin
      if (seq_start) starts <= starts + 16'h0001;
      if (hi_gate && lo_gate) shoot <= 1'b1;
    end
  end
endmodule

// File: pwm_timer_unit_tb.sv
// Self-checking bench for the PWM timer block.
`timescale 1ns/1ps
module pwm_timer_unit_tb;
  logic clk = 1'b0, arst_n = 1'b0, we = 1'b0, re = 1'b0, aux_clk = 1'b0;
  logic enc_a = 1'b0, enc_b = 1'b0, enc_idx = 1'b0, shoot, qirq, qdir;
  logic [1:0] aux_div = 2'h0;
  logic [10:0] addr = 11'h000;
  logic [15:0] wdata = 16'h0000, rdata, starts, v, c, p, n;
  logic [31:0] cap_in = 32'h0, pwm_out;
  logic [3:0] dt_hi, dt_lo, adc_st, tirq;
  logic [15:0] s [17];
  int bad_count = 0, checks_done = 0, hi, ph = 0;
  pwm_timer_unit dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .we(we), .re(re),
    .rdata(rdata), .aux_clk(aux_clk), .cap_in(cap_in), .pwm_out(pwm_out), .dt_hi(dt_hi),
    .dt_lo(dt_lo), .adc_conversion_sequencer_start(adc_st), .timer_irq(tirq), .enc_a(enc_a),
    .enc_b(enc_b), .enc_idx(enc_idx), .quadrature_decoder_irq(qirq),
    .quadrature_decoder_dir(qdir));
  gate_drive_model gdm (.clk(clk), .arst_n(arst_n), .hi_gate(dt_hi[0]), .lo_gate(dt_lo[0]),
    .seq_start(adc_st[0]), .starts(starts), .shoot(shoot));
  always #5 clk = ~clk;
  // Auxiliary clock at a quarter of the bus clock, the highest rate the pin filter passes.
  always @(posedge clk) begin
    aux_div <= aux_div + 2'h1;
    aux_clk <= aux_div[1];
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [10:0] a, output logic [15:0] d);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // Back-to-back reads sample the counter on seventeen consecutive cycles.
  task automatic burst(input logic [10:0] a);
    for (int i = 0; i < 18; i++) begin
      @(posedge clk);
      re <= (i < 17);
      addr <= a;
      @(negedge clk);
      if (i > 0) s[i-1] = rdata;
    end
  endtask
  task automatic run(output int h, output logic [15:0] k);
    logic [15:0] s0;
    h = 0;
    @(negedge clk);
    s0 = starts;
    repeat (64) begin
      @(negedge clk);
      h += pwm_out[0];
    end
    k = starts - s0;
  endtask
  // One quadrature edge; the gray order A then B counts up.
  task automatic step(input int dir);
    ph = (ph + dir) & 3;
    @(posedge clk);
    enc_a <= (ph == 1) || (ph == 2);
    enc_b <= (ph >= 2);
    repeat (8) @(posedge clk);
  endtask
  function automatic logic [15:0] nxt(input int m, input logic [15:0] a, input logic [15:0] b);
    if (m == 0) return (b == 16'h3) ? 16'h0 : b + 16'h1;
    if (b > a) return (b == 16'h3) ? 16'h2 : b + 16'h1;
    return (b == 16'h0) ? 16'h1 : b - 16'h1;
  endfunction
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    logic [10:0] ra [6] = '{11'h000, 11'h001, 11'h403, 11'h005, 11'h006, 11'h0ff};
    logic [15:0] re_v [6] = '{16'h0, 16'hffff, 16'hffff, 16'h0, 16'h0, 16'h0};
    logic [15:0] cfg [3] = '{16'h1004, 16'h1024, 16'h2004};
    logic [15:0] dly [3] = '{16'h0, 16'h0, 16'h0019};
    int hexp [3] = '{20, 44, 14};
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset values, with an unmapped offset reading zero.
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], v);
      chk("reset value", v, re_v[i]);
    end
    // Each counting style, period 3, checked cycle by cycle.
    wr(11'h000, 16'h0080);
    wr(11'h001, 16'h0003);
    for (int m = 0; m < 3; m++) begin
      wr(11'h000, 16'h0280 | 16'(m));
      burst(11'h002);
      for (int i = 2; i < 17; i++) chk("count step", s[i], nxt(m, s[i-2], s[i-1]));
    end
    // Divide by four on the bus clock, then the aux clock undivided: four ticks in 16 cycles.
    wr(11'h001, 16'h000f);
    for (int k = 0; k < 2; k++) begin
      wr(11'h000, k ? 16'h0284 : 16'h0290);
      burst(11'h002);
      n = 16'h0;
      for (int i = 1; i < 17; i++) n += 16'(s[i] != s[i-1]);
      chk("tick rate", n, 16'h0004);
    end
    // Single shot with the period interrupt enabled.
    wr(11'h000, 16'h0080);
    wr(11'h003, 16'hffff);
    wr(11'h000, 16'h0b80);
    repeat (40) @(posedge clk);
    rd(11'h000, v);
    chk("single shot enable", v, 16'h0980);
    chk("timer irq", {15'h0, tirq[0]}, 16'h0001);
    wr(11'h003, 16'h0300);
    repeat (3) @(posedge clk);
    chk("timer irq cleared", {15'h0, tirq[0]}, 16'h0000);
    // Channel 0 waveforms through the dead-time pair: plain, inverted, delayed.
    wr(11'h000, 16'h0080);
    wr(11'h001, 16'h001f);
    wr(11'h010, 16'h1004);
    wr(11'h020, 16'h000a);
    wr(11'h005, 16'h0006);
    wr(11'h006, 16'h0005);
    wr(11'h004, 16'h0001);
    wr(11'h000, 16'h0280);
    for (int i = 0; i < 3; i++) begin
      wr(11'h010, cfg[i]);
      wr(11'h030, dly[i]);
      repeat (40) @(posedge clk);
      run(hi, n);
      chk("pwm high cycles", 16'(hi), 16'(hexp[i]));
      chk("sequencer starts", n, 16'h0002);
    end
    chk("shoot through", {15'h0, shoot}, 16'h0000);
    // Capture on each edge choice with the counter frozen between events.
    for (int e = 1; e < 4; e++) begin
      wr(11'h010, 16'h0001 | 16'(e << 3));
      if (e == 1) rd(11'h020, p);
      for (int k = 0; k < 2; k++) begin
        wr(11'h000, 16'h0280);
        wr(11'h000, 16'h0080);
        rd(11'h002, c);
        @(posedge clk);
        cap_in[0] <= ~cap_in[0];
        repeat (8) @(posedge clk);
        rd(11'h020, v);
        if ((cap_in[0] && e[0]) || (!cap_in[0] && e[1])) p = c;
        chk("captured count", v, p);
      end
    end
    chk("capture output", {15'h0, pwm_out[0]}, 16'h0000);
    wr(11'h011, 16'h4040);
    rd(11'h003, v);
    chk("force", {15'h0, v[1]}, 16'h0001);
    // Quadrature x4: four edges up, then six down through the wrap at max 9.
    wr(11'h403, 16'h0009);
    wr(11'h400, 16'h0045);
    repeat (4) step(1);
    rd(11'h401, v);
    chk("encoder count up", v, 16'h0004);
    chk("direction up", {15'h0, qdir}, 16'h0001);
    repeat (6) step(3);
    rd(11'h401, v);
    chk("encoder count down", v, 16'h0008);
    chk("direction down", {15'h0, qdir}, 16'h0000);
    rd(11'h402, v);
    chk("wrap flag", {15'h0, v[3]}, 16'h0001);
    chk("encoder irq", {15'h0, qirq}, 16'h0001);
    @(posedge clk);
    enc_idx <= 1'b1;
    repeat (8) @(posedge clk);
    rd(11'h401, v);
    chk("index", v, 16'h0000);
    print_verdict();
  end
endmodule
